// ### hdl/esx_pkg.sv
// Package with constants, types and register map of the exception and exclusive monitor block
package esx_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_IRQ   = 31;
  localparam int NUM_SYS   = 7;
  localparam int NUM_EXC   = NUM_SYS + NUM_IRQ + 2;
  localparam int PRI_W     = 3;
  localparam int IDX_W     = 6;
  localparam int STACK_CYC = 8;

  // Exception slots: 0 nmi, 1 hard fault, 2..8 system handlers, 9.. irqs
  localparam logic [IDX_W-1:0] EXC_NMI   = 6'h00;
  localparam logic [IDX_W-1:0] EXC_HARD  = 6'h01;
  localparam logic [IDX_W-1:0] EXC_SYS0  = 6'h02;
  localparam logic [IDX_W-1:0] EXC_IRQ0  = 6'h09;
  localparam logic [IDX_W-1:0] EXC_NONE  = 6'h3f;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_IRQ_EN    = 12'h000;
  localparam logic [11:0] OFS_IRQ_PEND  = 12'h004;
  localparam logic [11:0] OFS_GROUP     = 12'h008;
  localparam logic [11:0] OFS_STATUS    = 12'h00c;
  localparam logic [11:0] OFS_ACT_LO    = 12'h010;
  localparam logic [11:0] OFS_ACT_HI    = 12'h014;
  localparam logic [11:0] OFS_PEND_LO   = 12'h018;
  localparam logic [11:0] OFS_PEND_HI   = 12'h01c;
  localparam logic [11:0] OFS_SYS_PEND  = 12'h020;
  localparam logic [11:0] OFS_PRI_BASE  = 12'h100;
  localparam logic [11:0] OFS_PRI_LAST  = 12'h194;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [PRI_W-1:0] PRI_RST   = 3'h0;
  localparam logic [2:0]       GROUP_RST = 3'h0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ESX_SZ_BYTE,
    ESX_SZ_HALF,
    ESX_SZ_WORD
  } esx_size_t;

  typedef enum logic [1:0] {
    ESX_EXC_INACTIVE,
    ESX_EXC_PENDING,
    ESX_EXC_ACTIVE,
    ESX_EXC_ACT_PEND
  } esx_exc_state_t;

  typedef struct packed {
    logic        load_excl;
    logic        store_excl;
    logic        clear_excl_tag;
    esx_size_t   size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } esx_mem_req_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] rdata;
    logic        status;
    logic        wr_en;
    logic [3:0]  wr_strb;
    logic [31:0] wr_word;
  } esx_mem_rsp_t;

endpackage

// ### hdl/esx_exc_excl.sv
// Exception state tracker, priority arbiter and exclusive access monitor
// ------------------------------------------------------------------
// ------------------------------------------------------------------
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
module esx_exc_excl
  import esx_pkg::*;
(
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Pipeline memory requests
  input  wire logic                req_valid,
  input  wire esx_mem_req_t        req,
  input  wire logic [31:0]         mem_rdata,
  output esx_mem_rsp_t             rsp,
  // Exception sources
  input  wire logic [NUM_IRQ-1:0]  irq_lines,
  input  wire logic                nmi_req,
  input  wire logic                hard_fault_req,
  input  wire logic [NUM_SYS-1:0]  sys_req,
  input  wire logic                handler_done,
  // Exception sequencing
  output logic                     handler_mode,
  output logic                     stack_push,
  output logic                     stack_pop,
  output logic                     vector_fetch,
  output logic [IDX_W-1:0]         cur_exc,
  output logic                     tail_chain
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Preemption part of a priority under the grouping setting
  function automatic logic [PRI_W-1:0] preempt_of(input logic [PRI_W-1:0] p,
                                                  input logic [2:0]       g);
    logic [PRI_W-1:0] m;
    m = (g >= 3'h3) ? 3'h0 : (3'h7 << g);
    return p & m;
  endfunction

  // Rank: lower is more urgent; nmi 0, hard fault 1, programmable 2 + preemption part of pri
  function automatic logic [3:0] rank_of(input int idx, input logic [PRI_W-1:0] p,
                                         input logic [2:0] g);
    if (idx == 0) return 4'h0;
    if (idx == 1) return 4'h1;
    return 4'h2 + {1'b0, preempt_of(p, g)};
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [NUM_IRQ-1:0] irq_en_r;
  logic [2:0]         group_r;
  logic [PRI_W-1:0]   pri_r   [NUM_EXC];
  logic [NUM_EXC-1:0] pend_r;
  logic [NUM_EXC-1:0] act_r;
  logic               tag_r;
  logic [31:0]        tag_addr_r;
  esx_size_t          tag_size_r;
  logic [IDX_W-1:0]   cur_r;
  logic [3:0]         cur_rank_r;
  logic [3:0]         stk_cnt_r;
  logic [IDX_W-1:0]   sel_r;

  typedef enum logic [1:0] {
    ESX_SEQ_IDLE,
    ESX_SEQ_ENTRY,
    ESX_SEQ_HANDLER,
    ESX_SEQ_EXIT
  } esx_seq_t;
  esx_seq_t seq_r;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic apb_wr;
  logic apb_rd;
  logic [31:0] sw_irq_set;
  logic [NUM_EXC-1:0] req_vec;
  logic [NUM_EXC-1:0] en_vec;
  logic [NUM_EXC-1:0] take_vec;

  assign apb_wr = psel && penable && pwrite && pready;
  assign apb_rd = psel && !penable && !pwrite;
  assign sw_irq_set = (apb_wr && paddr == OFS_IRQ_PEND) ? pwdata : 32'h0;

  assign req_vec = {irq_lines | sw_irq_set[NUM_IRQ-1:0], sys_req, hard_fault_req,
                    nmi_req};
  assign en_vec  = {irq_en_r, {NUM_SYS{1'b1}}, 2'b11};

  // Enter one-cycle access: pready high in access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable &&
                 !(paddr <= OFS_SYS_PEND ||
                   (paddr >= OFS_PRI_BASE && paddr <= OFS_PRI_LAST)) ;
    end
  end

  // Read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (apb_rd) begin
      prdata <= 32'h0;
      unique case (1'b1)
        paddr == OFS_IRQ_EN:   prdata <= {1'b0, irq_en_r};
        paddr == OFS_IRQ_PEND: prdata <= {1'b0, pend_r[NUM_EXC-1:EXC_IRQ0]};
        paddr == OFS_GROUP:    prdata <= {29'h0, group_r};
        paddr == OFS_STATUS:   prdata <= {22'h0, seq_r, cur_r, 1'b0, tag_r};
        paddr == OFS_ACT_LO:   prdata <= act_r[31:0];
        paddr == OFS_ACT_HI:   prdata <= {24'h0, act_r[NUM_EXC-1:32]};
        paddr == OFS_PEND_LO:  prdata <= pend_r[31:0];
        paddr == OFS_PEND_HI:  prdata <= {24'h0, pend_r[NUM_EXC-1:32]};
        paddr == OFS_SYS_PEND: prdata <= {23'h0, pend_r[8:0]};
        default: begin
          for (int i = 2; i < NUM_EXC; i++) begin
            if (paddr == OFS_PRI_BASE + 12'(4 * (i - 2)))
              prdata <= {29'h0, pri_r[i]};
          end
        end
      endcase
    end
  end

  // Configuration writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_en_r <= '0;
      group_r  <= GROUP_RST;
    end else if (apb_wr) begin
      if (paddr == OFS_IRQ_EN) irq_en_r <= pwdata[NUM_IRQ-1:0];
      if (paddr == OFS_GROUP)  group_r  <= pwdata[2:0];
    end
  end

  // Priority slots; nmi and hard fault stay fixed
  generate
    for (genvar i = 0; i < NUM_EXC; i++) begin : g_pri
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
          pri_r[i] <= PRI_RST;
        else if (i >= 2 && apb_wr && paddr == OFS_PRI_BASE + 12'(4 * (i - 2)))
          pri_r[i] <= pwdata[PRI_W-1:0];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  logic [IDX_W-1:0] best_idx;
  logic [3:0]       best_rank;
  logic [PRI_W-1:0] best_full;
  always_comb begin
    best_idx  = EXC_NONE;
    best_rank = 4'hf;
    best_full = 3'h7;
    for (int i = 0; i < NUM_EXC; i++) begin
      if (pend_r[i] && !act_r[i] && en_vec[i] &&
          (rank_of(i, pri_r[i], group_r) < best_rank ||
           (rank_of(i, pri_r[i], group_r) == best_rank && pri_r[i] < best_full))) begin
        best_idx  = IDX_W'(i);
        best_rank = rank_of(i, pri_r[i], group_r);
        best_full = pri_r[i];
      end
    end
  end

  logic preempt_ok;
  assign preempt_ok = (best_idx != EXC_NONE) && (best_rank < cur_rank_r);

  // ----------------------------------------------------------------
  // Exception sequencer
  // ----------------------------------------------------------------
  logic [3:0]       rank_stack_r [NUM_EXC];
  logic [IDX_W-1:0] prev_stack_r [NUM_EXC];
  logic             take;
  logic             finish;
  logic [3:0]       ret_rank;
  logic [IDX_W-1:0] ret_idx;
  logic             chain_ok;
  logic             chain;
  assign take   = (seq_r == ESX_SEQ_IDLE || seq_r == ESX_SEQ_HANDLER) && preempt_ok;
  assign finish = seq_r == ESX_SEQ_HANDLER && handler_done && !preempt_ok;
  // Rank and slot of the handler that the current one interrupted
  assign ret_rank = (cur_r < IDX_W'(NUM_EXC)) ? rank_stack_r[cur_r] : 4'hf;
  assign ret_idx  = (cur_r < IDX_W'(NUM_EXC)) ? prev_stack_r[cur_r] : EXC_NONE;
  // A pending one that beats the return target chains in without restacking
  assign chain_ok = (best_idx != EXC_NONE) && (best_rank < ret_rank);
  assign chain    = chain_ok && (finish || seq_r == ESX_SEQ_EXIT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_r        <= ESX_SEQ_IDLE;
      cur_r        <= EXC_NONE;
      cur_rank_r   <= 4'hf;
      stk_cnt_r    <= 4'h0;
      handler_mode <= 1'b0;
      stack_push   <= 1'b0;
      stack_pop    <= 1'b0;
      vector_fetch <= 1'b0;
      tail_chain   <= 1'b0;
      cur_exc      <= EXC_NONE;
      sel_r        <= EXC_NONE;
    end else begin
      vector_fetch <= 1'b0;
      tail_chain   <= 1'b0;
      unique case (seq_r)
        ESX_SEQ_IDLE, ESX_SEQ_HANDLER: begin
          if (take) begin
            seq_r        <= ESX_SEQ_ENTRY;
            handler_mode <= 1'b1;
            stack_push   <= 1'b1;
            vector_fetch <= 1'b1;
            stk_cnt_r    <= 4'(STACK_CYC - 1);
            sel_r        <= best_idx;
          end else if (finish && chain_ok) begin
            tail_chain   <= 1'b1;
            vector_fetch <= 1'b1;
            cur_r        <= best_idx;
            cur_exc      <= best_idx;
            cur_rank_r   <= best_rank;
          end else if (finish) begin
            seq_r     <= ESX_SEQ_EXIT;
            stack_pop <= 1'b1;
            stk_cnt_r <= 4'(STACK_CYC - 1);
          end
        end
        ESX_SEQ_ENTRY: begin
          stk_cnt_r <= stk_cnt_r - 4'h1;
          if (stk_cnt_r == 4'h0) begin
            stack_push <= 1'b0;
            seq_r      <= ESX_SEQ_HANDLER;
            cur_r      <= sel_r;
            cur_exc    <= sel_r;
            cur_rank_r <= rank_of(int'(sel_r), pri_r[sel_r], group_r);
          end
        end
        ESX_SEQ_EXIT: begin
          if (chain_ok) begin
            stack_pop    <= 1'b0;
            tail_chain   <= 1'b1;
            vector_fetch <= 1'b1;
            seq_r        <= ESX_SEQ_HANDLER;
            cur_r        <= best_idx;
            cur_exc      <= best_idx;
            cur_rank_r   <= best_rank;
          end else begin
            stk_cnt_r <= stk_cnt_r - 4'h1;
            if (stk_cnt_r == 4'h0 && ret_idx != EXC_NONE) begin
              // Back to the preempted handler
              stack_pop    <= 1'b0;
              seq_r        <= ESX_SEQ_HANDLER;
              cur_r        <= ret_idx;
              cur_exc      <= ret_idx;
              cur_rank_r   <= ret_rank;
            end else if (stk_cnt_r == 4'h0) begin
              stack_pop    <= 1'b0;
              seq_r        <= ESX_SEQ_IDLE;
              handler_mode <= 1'b0;
              cur_r        <= EXC_NONE;
              cur_exc      <= EXC_NONE;
              cur_rank_r   <= 4'hf;
            end
          end
        end
        default: seq_r <= ESX_SEQ_IDLE;
      endcase
    end
  end

  // Pending and active flags; request wins over the clear at activation
  generate
    for (genvar i = 0; i < NUM_EXC; i++) begin : g_state
      logic activate;
      assign activate = (take || chain) && best_idx == IDX_W'(i);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          pend_r[i]       <= 1'b0;
          act_r[i]        <= 1'b0;
          rank_stack_r[i] <= 4'hf;
          prev_stack_r[i] <= EXC_NONE;
        end else begin
          if (req_vec[i])
            pend_r[i] <= 1'b1;
          else if (activate)
            pend_r[i] <= 1'b0;
          if (activate) begin
            act_r[i]        <= 1'b1;
            rank_stack_r[i] <= take ? cur_rank_r : ret_rank;
            prev_stack_r[i] <= take ? cur_r : ret_idx;
          end else if (finish && cur_r == IDX_W'(i)) begin
            act_r[i] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Exclusive monitor
  // ----------------------------------------------------------------
  logic       exc_entry;
  logic       tag_match;
  logic [3:0] strb;
  assign exc_entry = take || chain;
  assign tag_match = tag_r;

  always_comb begin
    unique case (req.size)
      ESX_SZ_BYTE: strb = 4'h1 << req.addr[1:0];
      ESX_SZ_HALF: strb = req.addr[1] ? 4'hc : 4'h3;
      default:     strb = 4'hf;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tag_r      <= 1'b0;
      tag_addr_r <= 32'h0;
      tag_size_r <= ESX_SZ_WORD;
    end else if (exc_entry) begin
      tag_r <= 1'b0;
    end else if (req_valid && (req.clear_excl_tag || req.store_excl)) begin
      tag_r <= 1'b0;
    end else if (req_valid && req.load_excl) begin
      tag_r      <= 1'b1;
      tag_addr_r <= req.addr;
      tag_size_r <= req.size;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp <= '0;
    end else begin
      rsp.valid  <= req_valid && (req.load_excl || req.store_excl || req.clear_excl_tag);
      rsp.rdata  <= mem_rdata;
      rsp.status <= req_valid && req.store_excl && !(tag_match && !exc_entry);
      rsp.wr_en  <= req_valid && req.store_excl && tag_match && !exc_entry;
      rsp.wr_strb <= strb;
      // Lane placement: byte n of the word sits at address offset n
      rsp.wr_word <= req.wdata << {req.addr[1:0], 3'b000};
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_store_excl_word_fail;
    @(posedge pclk) disable iff (!presetn)
      (req_valid && req.store_excl && !tag_r) |=> (rsp.status && !rsp.wr_en);
  endproperty
  a_store_excl_word_fail: assert property (p_store_excl_word_fail) else $error("store without tag wrote");

  property p_store_excl_word_clears;
    @(posedge pclk) disable iff (!presetn)
      (req_valid && req.store_excl) |=> !tag_r;
  endproperty
  a_store_excl_word_clears: assert property (p_store_excl_word_clears) else $error("tag kept after store");

  property p_entry_clears;
    @(posedge pclk) disable iff (!presetn) take |=> !tag_r;
  endproperty
  a_entry_clears: assert property (p_entry_clears) else $error("tag kept on exception");

  sequence s_entry;
    take ##1 (stack_push && vector_fetch && handler_mode);
  endsequence
  property p_entry;
    @(posedge pclk) disable iff (!presetn) take |-> s_entry;
  endproperty
  a_entry: assert property (p_entry) else $error("entry not parallel");

  property p_push_len;
    @(posedge pclk) disable iff (!presetn)
      $rose(stack_push) |-> stack_push [*8] ##1 !stack_push;
  endproperty
  a_push_len: assert property (p_push_len) else $error("stacking length wrong");

  property p_tail;
    @(posedge pclk) disable iff (!presetn) tail_chain |-> !stack_push && handler_mode;
  endproperty
  a_tail: assert property (p_tail) else $error("tail chain restacked");

  property p_clear_excl_tag;
    @(posedge pclk) disable iff (!presetn)
      (req_valid && req.clear_excl_tag) |=> !tag_r;
  endproperty
  a_clear_excl_tag: assert property (p_clear_excl_tag) else $error("clear left tag");

  property p_load_excl_word;
    @(posedge pclk) disable iff (!presetn)
      (req_valid && req.load_excl && !req.store_excl && !req.clear_excl_tag && !exc_entry)
        |=> tag_r;
  endproperty
  a_load_excl_word: assert property (p_load_excl_word) else $error("load did not tag");

  property p_pend;
    @(posedge pclk) disable iff (!presetn) irq_lines[0] |=> pend_r[EXC_IRQ0];
  endproperty
  a_pend: assert property (p_pend) else $error("request not pending");

endmodule

// ### verif/esx_mem_model.sv
// Memory and pipeline side model answering exclusive loads and stores
`timescale 1ns/1ps
module esx_mem_model
  import esx_pkg::*;
(
  // Clock
  input  wire logic         pclk,
  // Pipeline side
  input  wire logic         req_valid,
  input  wire esx_mem_req_t req,
  input  wire esx_mem_rsp_t rsp,
  output logic [31:0]       mem_rdata
);
  // ----------------------------------------------------------------
  // Storage, byte value equals its byte address
  // ----------------------------------------------------------------
  logic [31:0] mem [4];
  logic [1:0]  wa_r;

  initial begin
    for (int i = 0; i < 4; i++) begin
      mem[i] = {8'(4*i+3), 8'(4*i+2), 8'(4*i+1), 8'(4*i)};
    end
  end

  // Idle cycles show inverted data, never the last word
  always_comb begin
    mem_rdata = req_valid ? mem[req.addr[3:2]] : ~mem[req.addr[3:2]];
  end

  // Store lands on the word its request addressed
  always @(posedge pclk) begin
    if (req_valid && req.store_excl) wa_r <= req.addr[3:2];
    for (int b = 0; b < 4; b++) begin
      if (rsp.wr_en && rsp.wr_strb[b]) mem[wa_r][8*b+:8] <= rsp.wr_word[8*b+:8];
    end
  end
endmodule

// ### verif/esx_exc_excl_tb_top.sv
// Testbench for the exception tracker and exclusive monitor
`timescale 1ns/1ps
module esx_exc_excl_tb_top;
  import esx_pkg::*;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, req_valid;
  logic               nmi_req, hard_fault_req, handler_done, handler_mode;
  logic               stack_push, stack_pop, vector_fetch, tail_chain;
  logic [11:0]        paddr;
  logic [31:0]        pwdata, prdata, mem_rdata, q;
  logic               r;
  esx_mem_req_t       req;
  esx_mem_rsp_t       rsp;
  logic [NUM_IRQ-1:0] irq_lines;
  logic [NUM_SYS-1:0] sys_req;
  logic [IDX_W-1:0]   cur_exc;
  int                 fail_count = 0, n_checks = 0, tc_cnt = 0, pop_cnt = 0, k, p;
  esx_size_t          xz[3] = '{ESX_SZ_BYTE, ESX_SZ_HALF, ESX_SZ_WORD};
  logic [31:0]        xa[3] = '{32'h6, 32'ha, 32'hc};
  logic [31:0]        xd[3] = '{32'haa, 32'hbbcc, 32'h11223344};
  logic [3:0]         xs[3] = '{4'h4, 4'hc, 4'hf};
  logic [31:0]        xm[3] = '{32'h07aa0504, 32'hbbcc0908, 32'h11223344};

  esx_exc_excl esx_exc_excl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req(req),
    .mem_rdata(mem_rdata), .rsp(rsp), .irq_lines(irq_lines), .nmi_req(nmi_req),
    .hard_fault_req(hard_fault_req), .sys_req(sys_req), .handler_done(handler_done),
    .handler_mode(handler_mode), .stack_push(stack_push), .stack_pop(stack_pop),
    .vector_fetch(vector_fetch), .cur_exc(cur_exc), .tail_chain(tail_chain));
  esx_mem_model esx_mem_model_inst (.pclk(pclk), .req_valid(req_valid), .req(req),
    .rsp(rsp), .mem_rdata(mem_rdata));

  // ----------------------------------------------------------------
  // Clock, event counters, watchdog
  // ----------------------------------------------------------------
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    if (tail_chain === 1'b1) tc_cnt++;
    if (stack_pop === 1'b1) pop_cnt++;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input string n, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] o, output logic er);
    int n;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    o = prdata;
    er = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] o;
    logic er;
    apb(1, a, d, o, er);
    check("pslverr", er, 0);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, e);
    logic [31:0] o;
    logic er;
    apb(0, a, 0, o, er);
    check("prdata", o & m, e);
  endtask
  task automatic xop(input logic ld, st, cl, input esx_size_t sz, input logic [31:0] a, d);
    @(posedge pclk);
    req_valid <= 1;
    req <= '{ld, st, cl, sz, a, d};
    @(posedge pclk);
    req_valid <= 0;
    req <= '0;
    #1;
  endtask
  task automatic done();
    @(posedge pclk) handler_done <= 1;
    @(posedge pclk) handler_done <= 0;
  endtask
  task automatic wait_exc(input logic [IDX_W-1:0] e);
    for (int n = 0; n < 100 && cur_exc !== e; n++) @(posedge pclk);
    check("cur_exc", cur_exc, e);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    req_valid = 0; req = '0; irq_lines = 0; nmi_req = 0; hard_fault_req = 0;
    sys_req = 0; handler_done = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1;
    rdc(OFS_PRI_BASE, 32'hffffffff, 0);
    rdc(OFS_PRI_LAST, 32'hffffffff, 0);
    rdc(OFS_ACT_LO, 32'hffffffff, 0);
    rdc(OFS_PEND_LO, 32'hffffffff, 0);
    rdc(OFS_STATUS, 32'h1, 0);
    wr(OFS_PRI_LAST, 32'hff);
    rdc(OFS_PRI_LAST, 32'hffffffff, 7);
    wr(OFS_GROUP, 32'h3);
    rdc(OFS_GROUP, 32'h7, 3);
    apb(0, 12'h030, 0, q, r);
    check("pslverr", r, 1);
    check("prdata", q, 0);
    // Exclusive pairs at each size, then a store with no tag
    for (int i = 0; i < 3; i++) begin
      xop(1, 0, 0, xz[i], xa[i], 0);
      check("valid", rsp.valid, 1);
      rdc(OFS_STATUS, 32'h1, 1);
      xop(0, 1, 0, xz[i], xa[i], xd[i]);
      check("status", rsp.status, 0);
      check("wr_strb", rsp.wr_strb, xs[i]);
      xop(0, 1, 0, xz[i], xa[i], 32'hffffffff);
      check("status", rsp.status, 1);
      check("wr_en", rsp.wr_en, 0);
    end
    repeat (2) @(posedge pclk);
    for (int i = 0; i < 3; i++) check("mem", esx_mem_model_inst.mem[i+1], xm[i]);
    xop(1, 0, 0, ESX_SZ_WORD, 0, 0);
    check("rdata", rsp.rdata, 32'h03020100);
    xop(0, 0, 1, ESX_SZ_WORD, 0, 0);
    xop(0, 1, 0, ESX_SZ_WORD, 0, 1);
    check("status", rsp.status, 1);
    // Interrupt entry, preemption and tail-chaining
    irq_lines[0] <= 1'b1;
    rdc(OFS_PEND_LO, 32'h200, 32'h200);
    xop(1, 0, 0, ESX_SZ_WORD, 0, 0);
    wr(OFS_IRQ_EN, 32'h3);
    for (k = 0; k < 50 && stack_push !== 1'b1; k++) @(posedge pclk);
    check("vector_fetch", vector_fetch, 1);
    check("handler_mode", handler_mode, 1);
    xop(0, 1, 0, ESX_SZ_WORD, 0, 32'h5a);
    check("status", rsp.status, 1);
    xop(1, 0, 0, ESX_SZ_WORD, 0, 0);
    xop(0, 1, 0, ESX_SZ_WORD, 0, 32'h5a);
    check("status", rsp.status, 0);
    wait_exc(EXC_IRQ0);
    rdc(OFS_ACT_LO, 32'h200, 32'h200);
    rdc(OFS_PEND_LO, 32'h200, 32'h200);
    irq_lines[0] <= 1'b0;
    @(posedge pclk) nmi_req <= 1;
    @(posedge pclk) nmi_req <= 0;
    wait_exc(EXC_NMI);
    rdc(OFS_ACT_LO, 32'h201, 32'h201);
    done();
    wait_exc(EXC_IRQ0);
    wr(OFS_IRQ_PEND, 32'h2);
    rdc(OFS_PEND_LO, 32'h400, 32'h400);
    p = pop_cnt;
    k = tc_cnt;
    done();
    for (int n = 0; n < 40 && tc_cnt == k; n++) @(posedge pclk);
    check("tail_chain", 32'(tc_cnt - k), 1);
    check("stack_pop", 32'(pop_cnt - p), 0);
    repeat (3) if (handler_mode === 1'b1) begin
      repeat (20) @(posedge pclk);
      done();
    end
    repeat (20) @(posedge pclk);
    check("handler_mode", handler_mode, 0);
    check("stack_pop", 32'(pop_cnt > p), 1);
    rdc(OFS_ACT_LO, 32'hffffffff, 0);
    stop_test();
  end
endmodule
